// ### verilog/bsseq_map.svh
// Register offsets, field positions, reset values and timing counts
// What this block does
// - Hold shutdown until enable rises, then await POR
// - Start only with supplies valid; power-good after regulation
// - About 170 us calibration latches both mode pins
// - Await PLL lock before any clock output pulses
// - Preload soft-start ramp 50 us, gates off
// - Soft-start switches high side only, low side off
// - Feedback below threshold: fixed 50 kHz, minimum on-time
// - Feedback already high: start at target frequency
// - Soft-start ends 0.5 ms after ramp clamp flag
// - Forced PWM after soft-start: complementary gate drive
// - Zero-current mode turns low side off at zero
// - Soft-start end releases power-good pull-down
// - Enable low clears latched modes and sync-loss status, returns to shutdown
// - High-side rise follows sync edge by about 325 ns
// - Slew gradually onto an appearing external clock
// - Sync lost 6 ms: stop, restart after 50 ms
// - Clock output 270 ns pulse, 180 degrees from high side
`ifndef BSSEQ_MAP_SVH
`define BSSEQ_MAP_SVH
`define BSSEQ_CLK_MHZ 25
`define BSSEQ_T_CAL_US 170
`define BSSEQ_CAL_CYC (`BSSEQ_T_CAL_US * `BSSEQ_CLK_MHZ)
`define BSSEQ_T_PREB_US 50
`define BSSEQ_PREB_CYC (`BSSEQ_T_PREB_US * `BSSEQ_CLK_MHZ)
`define BSSEQ_T_SSEND_US 500
`define BSSEQ_SSEND_CYC (`BSSEQ_T_SSEND_US * `BSSEQ_CLK_MHZ)
`define BSSEQ_T_LOSS_US 6000
`define BSSEQ_LOSS_CYC (`BSSEQ_T_LOSS_US * `BSSEQ_CLK_MHZ)
`define BSSEQ_T_RESTART_US 50000
`define BSSEQ_RESTART_CYC (`BSSEQ_T_RESTART_US * `BSSEQ_CLK_MHZ)
`define BSSEQ_F_MIN_KHZ 50
`define BSSEQ_MINF_CYC ((`BSSEQ_CLK_MHZ * 1000) / `BSSEQ_F_MIN_KHZ)
`define BSSEQ_T_SYNC_NS 325
`define BSSEQ_SYNC_CYC ((`BSSEQ_T_SYNC_NS * `BSSEQ_CLK_MHZ) / 1000)
`define BSSEQ_T_CKOUT_NS 270
`define BSSEQ_CKOUT_CYC ((`BSSEQ_T_CKOUT_NS * `BSSEQ_CLK_MHZ + 999) / 1000)
`define BSSEQ_T_MINON_NS 200
`define BSSEQ_MINON_CYC ((`BSSEQ_T_MINON_NS * `BSSEQ_CLK_MHZ + 999) / 1000)
`define BSSEQ_OFS_PERIOD 8'h00
`define BSSEQ_OFS_STATUS 8'h04
`define BSSEQ_OFS_IRQ_STAT 8'h08
`define BSSEQ_OFS_IRQ_MASK 8'h0c
`define BSSEQ_PERIOD_RST 16'h0053
`define BSSEQ_ST_STATE_LSB 0
`define BSSEQ_ST_FAULT_BIT 4
`define BSSEQ_ST_ZCM_BIT 5
`define BSSEQ_ST_SYNC_BIT 6
`define BSSEQ_ST_LOWF_BIT 7
`define BSSEQ_ST_POWER_GOOD_OUTPUT_BIT 8
`define BSSEQ_IRQ_POWER_GOOD_OUTPUT 0
`define BSSEQ_IRQ_LOSS 1
`define BSSEQ_IRQ_ENOFF 2
`define BSSEQ_IRQ_RESTART 3
`endif

// ### verilog/bsseq_pkg.sv
// Types shared by the start-up sequencer and its oscillator
package bsseq_pkg;
	// Sequencer phases, power-up order
	typedef enum logic [2:0] {
		ST_SHUTDOWN, ST_WAIT_POR, ST_CALIB, ST_WAIT_LOCK,
		ST_PREBIAS, ST_SOFTSTART, ST_RUN, ST_HOLDOFF
	} bsseq_state_t;

	// Whole state of the sequencer
	typedef struct packed {
		bsseq_state_t st;
		logic [20:0] tmr;      // Phase timer
		logic [17:0] loss;     // Cycles since last sync edge
		logic [15:0] ext_per;  // Measured sync period
		logic [15:0] period;   // Software target period
		logic [3:0] on_cnt;    // High-side on-time counter
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic sync_prev, sync_act, clamp_seen, lowf, load;
		logic fault_mode, zcm, hs, ls, ckout, pg_oe, preload, ssr, irq;
		logic pready, pslverr;
		logic [31:0] prdata;
	} bsseq_top_t;

	// Whole state of the oscillator
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] per;
		logic [3:0] ckw;
		logic cyc;
	} bsseq_osc_t;
endpackage

// ### verilog/bsseq_osc_if.sv
// Link between the sequencer and its switching oscillator
`timescale 1ns/1ps
`default_nettype none
interface bsseq_osc_if;
	logic run;            // Oscillator may count
	logic load;           // Take target period at once
	logic sync_act;       // External clock present
	logic sync_edge;      // Rising edge of external clock
	logic [15:0] target;  // Period to slew toward
	logic cyc;            // Start of switching cycle
	logic ck;             // Clock output level
	modport ctl (output run, load, sync_act, sync_edge, target,
		input cyc, ck);
	modport osc (input run, load, sync_act, sync_edge, target,
		output cyc, ck);
endinterface
`default_nettype wire

// ### verilog/bsseq_osc.sv
// Switching oscillator with slew, sync phase snap and clock output
`timescale 1ns/1ps
`default_nettype none
`include "bsseq_map.svh"
module bsseq_osc #(
	parameter logic [15:0] SYNC_CYC = 16'(`BSSEQ_SYNC_CYC),
	parameter logic [3:0] CKOUT_CYC = 4'(`BSSEQ_CKOUT_CYC)
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sequencer side
	bsseq_osc_if.osc o
);
	import bsseq_pkg::*;

	bsseq_osc_t q, n;

	// Next state: count, slew, snap phase, shape the clock output
	always_comb begin
		n = q;
		n.cyc = 1'b0;
		if (!o.run) begin
			// Stopped: nothing pulses before lock
			n.cnt = '0;
			n.ckw = '0;
		end else if (o.load) begin
			n.per = o.target;
			n.cnt = '0;
		end else begin
			if (q.cnt >= q.per - 16'h0001) begin
				n.cnt = '0;
				n.cyc = 1'b1;
				// One cycle of period change per switching cycle
				if (q.per < o.target) n.per = q.per + 16'h0001;
				else if (q.per > o.target) n.per = q.per - 16'h0001;
			end else begin
				n.cnt = q.cnt + 16'h0001;
			end
			// Once on frequency, each sync edge sets the next start
			if (o.sync_act && o.sync_edge && q.per == o.target &&
				q.per > SYNC_CYC) begin
				n.cnt = q.per - SYNC_CYC;
			end
			// Pulse starts half a period after the cycle start
			if (q.cnt == (q.per >> 1)) begin
				n.ckw = CKOUT_CYC;
			end else if (q.ckw != 4'h0) begin
				n.ckw = q.ckw - 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{cnt: 16'h0000, per: `BSSEQ_PERIOD_RST, ckw: 4'h0,
				cyc: 1'b0};
		end else begin
			q <= n;
		end
	end

	assign o.cyc = q.cyc;
	assign o.ck = (q.ckw != 4'h0);
endmodule // bsseq_osc
`default_nettype wire

// ### verilog/bsseq_top.sv
// Buck start-up sequencer with sync clock handling and APB registers
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bsseq_map.svh"
module bsseq_top #(
	parameter int unsigned CAL_CYC = `BSSEQ_CAL_CYC,
	parameter int unsigned SSEND_CYC = `BSSEQ_SSEND_CYC,
	parameter int unsigned LOSS_CYC = `BSSEQ_LOSS_CYC,
	parameter int unsigned RESTART_CYC = `BSSEQ_RESTART_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Comparator flags
	input wire logic en_rise_ok,
	input wire logic en_fall_low,
	input wire logic drv_supply_por_ok,
	input wire logic vin_ok,
	input wire logic vcc_ok,
	input wire logic pll_locked,
	input wire logic fb_below_low,
	input wire logic ss_clamp_reached,
	input wire logic comp_above_offset,
	input wire logic pwm_trip,
	input wire logic inductor_zero,
	// Mode pins and external clock
	input wire logic fault_response_select,
	input wire logic light_load_choice,
	input wire logic freq_set_sync_input,
	// Power stage and status pins
	output logic high_side_gate,
	output logic low_side_gate,
	output logic switching_clock_output,
	output logic power_good_out,
	output logic power_good_oe,
	output logic softstart_preload,
	output logic softstart_run,
	output logic irq
);
	import bsseq_pkg::*;

	// How the sequencer hangs together
	//
	// Phases follow one another in power-up order:
	//   shutdown, wait for supplies, calibrate, wait for lock,
	//   preload, soft-start, run, and a hold-off after sync loss.
	// Every phase change happens on a clock edge and is decided in
	// one combinational block, so the whole block sees one state.
	//
	// Timing
	//   Phase intervals are counted in pclk cycles by one shared phase
	//   timer; the sync gap and the on-time have their own counters.
	//   The timer is cleared on each entry to a timed phase except a hold-off entered from preload or from soft-start after the clamp flag.
	//   Long intervals are parameters so that a bench can shorten
	//   them. Only the preload length is fixed here.
	//
	// Calibration
	//   The two mode pins are sampled on every cycle of the phase and
	//   the last value is kept. A pin that settles late during the
	//   phase is therefore still taken correctly.
	//
	// Oscillator
	//   The oscillator runs only from lock onward, so no clock output
	//   pulse can appear before the lock flag has been seen.
	//   Its target period is picked here:
	//     minimum frequency while feedback is still low,
	//     the measured sync period while an external clock is present,
	//     the software period otherwise.
	//   Period changes, except the loads at preload and soft-start entry, are
	//   slewed one cycle per switching cycle, which keeps the loop from seeing a step when sync appears.
	//
	// Gate drive
	//   Gates switch only in soft-start and run, and only while the
	//   error output is above the ramp offset.
	//   The high side starts on each oscillator cycle start and ends
	//   either after the minimum on-time in the low-frequency phase or
	//   on the current trip otherwise.
	//   The low side is kept off through all of soft-start. In run it
	//   fills the gap from high-side end to the next cycle start, and
	//   in zero-current mode it also drops on the zero indication.
	//   There is no extra dead-time here; the external driver adds it.
	//
	// Sync loss
	//   A sync edge that does not come within the loss interval drops
	//   the sync presence. If the stage was switching, it stops and
	//   the sequencer waits out the hold-off before a full restart.
	//
	// Enable low
	//   Enable low wins over every phase. It forgets the latched modes
	//   and the sync-loss status, then flags the drop itself.
	//
	// Registers
	//   The bus answers one cycle after setup with no wait states.
	//   Read data is latched at setup and stands until the next one.
	//   An unmapped offset answers with an error and reads zero.
	//
	// Limitation
	//   Comparator flags are taken as already synchronous to pclk.
	//   A flag that toggles faster than a cycle is simply missed.

	localparam logic [20:0] PREB_CYC = 21'(`BSSEQ_PREB_CYC);
	localparam logic [15:0] MINF_CYC = 16'(`BSSEQ_MINF_CYC);
	localparam logic [3:0] MINON_CYC = 4'(`BSSEQ_MINON_CYC);

	bsseq_top_t q, n;
	bsseq_osc_if oif ();
	logic sync_edge;     // Rising edge on the sync pin
	logic acc;           // APB access completes this edge
	logic drive;         // Gates may switch
	logic [3:0] ev;      // Interrupt events this cycle
	logic [3:0] clr;     // Write-one-to-clear mask

	// Oscillator: runs from lock onward
	bsseq_osc u_osc (
		.pclk(pclk),
		.presetn(presetn),
		.o(oif.osc)
	);

	// Drive the oscillator from registered state only
	always_comb begin
		oif.run = (q.st == ST_PREBIAS) || (q.st == ST_SOFTSTART) ||
			(q.st == ST_RUN);
		oif.load = q.load;
		oif.sync_act = q.sync_act;
		oif.sync_edge = q.sync_prev && !q.loss[0] && (q.loss == '0);
		// Low-frequency start wins over every other target
		if (q.lowf) oif.target = MINF_CYC;
		else if (q.sync_act) oif.target = q.ext_per;
		else oif.target = q.period;
	end

	// Next state of the whole sequencer
	always_comb begin
		n = q;
		ev = 4'h0;
		clr = 4'h0;
		n.load = 1'b0;
		n.preload = 1'b0;
		sync_edge = freq_set_sync_input && !q.sync_prev;
		n.sync_prev = freq_set_sync_input;

		// APB: answer in the cycle after setup, no wait states
		acc = psel && penable && q.pready;
		n.pready = psel && !penable && !q.pready;
		if (psel && !penable) begin
			n.prdata = 32'h0000_0000;
			n.pslverr = 1'b0;
			unique case (paddr)
				`BSSEQ_OFS_PERIOD: n.prdata[15:0] = q.period;
				`BSSEQ_OFS_STATUS: begin
					n.prdata[`BSSEQ_ST_STATE_LSB +: 3] = q.st;
					n.prdata[`BSSEQ_ST_FAULT_BIT] = q.fault_mode;
					n.prdata[`BSSEQ_ST_ZCM_BIT] = q.zcm;
					n.prdata[`BSSEQ_ST_SYNC_BIT] = q.sync_act;
					n.prdata[`BSSEQ_ST_LOWF_BIT] = q.lowf;
					n.prdata[`BSSEQ_ST_POWER_GOOD_OUTPUT_BIT] = !q.pg_oe;
				end
				`BSSEQ_OFS_IRQ_STAT: n.prdata[3:0] = q.irq_stat;
				`BSSEQ_OFS_IRQ_MASK: n.prdata[3:0] = q.irq_mask;
				// Unmapped: error answer, reads zero
				default: n.pslverr = 1'b1;
			endcase
		end
		if (acc && pwrite) begin
			unique case (paddr)
				`BSSEQ_OFS_PERIOD: n.period = pwdata[15:0];
				`BSSEQ_OFS_IRQ_STAT: clr = pwdata[3:0];
				`BSSEQ_OFS_IRQ_MASK: n.irq_mask = pwdata[3:0];
				default: ;
			endcase
		end

		// Sync watch: measure period, drop presence after a long gap
		if (sync_edge) begin
			// Counter width holds the slowest legal sync period
			n.ext_per = 16'(q.loss + 18'h00001);
			n.loss = '0;
			n.sync_act = (q.loss < 18'(LOSS_CYC)) && q.sync_prev == 1'b0
				&& q.ext_per != 16'h0000;
		end else if (q.loss != 18'(LOSS_CYC)) begin
			n.loss = q.loss + 18'h00001;
		end else if (q.sync_act) begin
			// Gap reached: external clock is gone
			n.sync_act = 1'b0;
			if (q.st == ST_PREBIAS || q.st == ST_SOFTSTART ||
				q.st == ST_RUN) begin
				ev[`BSSEQ_IRQ_LOSS] = 1'b1;
				n.st = ST_HOLDOFF;
				n.tmr = '0;
			end
		end

		// Phase sequence
		unique case (q.st)
			ST_SHUTDOWN: begin
				// Nothing runs until enable crosses its rising level
				if (en_rise_ok) n.st = ST_WAIT_POR;
			end
			ST_WAIT_POR: begin
				// Driver supply, input and bias supplies all good
				if (drv_supply_por_ok && vin_ok && vcc_ok) begin
					n.st = ST_CALIB;
					n.tmr = '0;
				end
			end
			ST_CALIB: begin
				// Mode pins are sampled over the whole phase
				n.fault_mode = fault_response_select;
				n.zcm = light_load_choice;
				n.tmr = q.tmr + 21'h000001;
				if (q.tmr == 21'(CAL_CYC - 1)) begin
					n.st = ST_WAIT_LOCK;
				end
			end
			ST_WAIT_LOCK: begin
				if (pll_locked) begin
					n.st = ST_PREBIAS;
					n.tmr = '0;
					n.load = 1'b1;
				end
			end
			ST_PREBIAS: begin
				// Ramp follows feedback; gates stay off
				n.tmr = q.tmr + 21'h000001;
				if (q.tmr == PREB_CYC - 21'h000001) begin
					n.st = ST_SOFTSTART;
					n.tmr = '0;
					n.clamp_seen = 1'b0;
					n.lowf = fb_below_low;
					n.load = 1'b1;
				end
			end
			ST_SOFTSTART: begin
				// Leave minimum frequency once feedback is up
				if (!fb_below_low) n.lowf = 1'b0;
				if (ss_clamp_reached) n.clamp_seen = 1'b1;
				if (q.clamp_seen) begin
					n.tmr = q.tmr + 21'h000001;
					if (q.tmr == 21'(SSEND_CYC - 1)) begin
						n.st = ST_RUN;
						ev[`BSSEQ_IRQ_POWER_GOOD_OUTPUT] = 1'b1;
					end
				end
			end
			ST_RUN: ;
			ST_HOLDOFF: begin
				// Quiet interval before a fresh start-up
				n.tmr = q.tmr + 21'h000001;
				if (q.tmr == 21'(RESTART_CYC - 1)) begin
					n.st = ST_WAIT_POR;
					ev[`BSSEQ_IRQ_RESTART] = 1'b1;
				end
			end
		endcase

		// Enable low overrides every phase and forgets latched modes
		if (en_fall_low && q.st != ST_SHUTDOWN) begin
			n.st = ST_SHUTDOWN;
			n.tmr = '0;
			n.fault_mode = 1'b0;
			n.zcm = 1'b0;
			n.lowf = 1'b0;
			n.clamp_seen = 1'b0;
			ev[`BSSEQ_IRQ_ENOFF] = 1'b1;
			clr[`BSSEQ_IRQ_LOSS] = 1'b1;
		end

		// Sticky status: a new event beats a clear in the same cycle
		n.irq_stat = (q.irq_stat & ~clr) | ev;
		n.irq = |(n.irq_stat & n.irq_mask);

		// Gate drive: only in soft-start and run, only past offset
		drive = (n.st == ST_SOFTSTART || n.st == ST_RUN) &&
			comp_above_offset;
		n.ssr = (n.st == ST_SOFTSTART || n.st == ST_RUN);
		// Preload follows the phase itself, so it never overlaps
		// the first high-side pulse of soft-start
		n.preload = (n.st == ST_PREBIAS);
		if (!drive) begin
			n.hs = 1'b0;
			n.on_cnt = '0;
		end else if (oif.cyc) begin
			n.hs = 1'b1;
			n.on_cnt = '0;
		end else if (q.hs) begin
			n.on_cnt = q.on_cnt + 4'h1;
			// Low-frequency phase uses the minimum on-time only
			if (q.lowf) begin
				if (q.on_cnt == MINON_CYC - 4'h1) n.hs = 1'b0;
			end else if (pwm_trip) begin
				n.hs = 1'b0;
			end
		end
		// Low side only after soft-start, never with the high side
		if (n.st != ST_RUN || !drive || oif.cyc) begin
			n.ls = 1'b0;
		end else if (q.zcm && inductor_zero) begin
			n.ls = 1'b0;
		end else if (q.hs && !n.hs) begin
			n.ls = 1'b1;
		end
		n.ckout = oif.ck;
		n.pg_oe = (n.st != ST_RUN);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= ST_SHUTDOWN;
			q.period <= `BSSEQ_PERIOD_RST;
			q.pg_oe <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// Ports come straight from the state register; power_good_out is tied low
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign high_side_gate = q.hs;
	assign low_side_gate = q.ls;
	assign switching_clock_output = q.ckout;
	assign power_good_out = 1'b0;
	assign power_good_oe = q.pg_oe;
	assign softstart_preload = q.preload;
	assign softstart_run = q.ssr;
	assign irq = q.irq;
endmodule // bsseq_top
`default_nettype wire

// ### test/bsseq_properties.sv
// Checker of the sequencer's gate, clock output and power-good rules
`timescale 1ns/1ps
`default_nettype none
module bsseq_properties #(
	parameter int unsigned SSEND_CYC = 12500
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Watched inputs
	input wire logic en_fall_low,
	input wire logic comp_above_offset,
	input wire logic inductor_zero,
	input wire logic light_load_choice,
	input wire logic ss_clamp_reached,
	// Watched outputs
	input wire logic high_side_gate,
	input wire logic low_side_gate,
	input wire logic switching_clock_output,
	input wire logic power_good_oe,
	input wire logic softstart_preload,
	input wire logic softstart_run
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [11:0] pre_cnt_q; // Cycles spent in the current preload phase
	// Count preload length; cleared between phases
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pre_cnt_q <= 12'h000;
		else
			pre_cnt_q <= softstart_preload ? pre_cnt_q + 12'h001 : 12'h000;
	end
	AST_NO_OVERLAP: assert property (!(high_side_gate && low_side_gate))
		else $error("both gates on together");
	AST_PRELOAD_OFF: assert property (softstart_preload |->
		!high_side_gate && !low_side_gate) else $error("gate on in preload");
	AST_PRELOAD_LEN: assert property ($fell(softstart_preload) &&
		softstart_run |-> pre_cnt_q == 12'h4e2) else $error("preload length");
	AST_LS_RUN_ONLY: assert property (low_side_gate |-> !power_good_oe)
		else $error("low side on before soft-start end");
	AST_HS_CAUSE: assert property ($rose(high_side_gate) |->
		softstart_run && $past(comp_above_offset)) else $error("stray pulse");
	AST_CKOUT_WIDTH: assert property ($rose(switching_clock_output) |->
		switching_clock_output[*7] ##1 !switching_clock_output)
		else $error("clock output width");
	AST_ZERO_CUT: assert property (light_load_choice && inductor_zero &&
		!power_good_oe |=> !low_side_gate) else $error("low side kept on");
	AST_EN_DROP: assert property (en_fall_low && softstart_run |->
		##[1:2] !softstart_run && power_good_oe) else $error("no shutdown");
	AST_PG_RELEASE: assert property ($fell(power_good_oe) |->
		softstart_run && $past(ss_clamp_reached, SSEND_CYC))
		else $error("power-good released early");
	// Main scenarios reached
	cover property ($fell(power_good_oe));
	cover property ($rose(low_side_gate));
	cover property (light_load_choice && inductor_zero && low_side_gate);
endmodule // bsseq_properties
bind bsseq_top bsseq_properties #(.SSEND_CYC(SSEND_CYC)) bsseq_properties_inst (
	.pclk, .presetn, .en_fall_low, .comp_above_offset, .inductor_zero,
	.light_load_choice, .ss_clamp_reached, .high_side_gate, .low_side_gate,
	.switching_clock_output, .power_good_oe, .softstart_preload,
	.softstart_run);
`default_nettype wire

// ### test/bsseq_sync_src.sv
// External sync clock source and system enable logic
`timescale 1ns/1ps
`default_nettype none
module bsseq_sync_src #(
	parameter int HALF = 50 // Half period in pclk cycles, 250 kHz
) (
	// Clock
	input wire logic pclk,
	// Requests from the bench
	input wire logic en,
	input wire logic sync_on,
	// Pins toward the block
	output logic en_rise_ok,
	output logic en_fall_low,
	output logic sync = 1'b0
);
	int cnt = 0; // Cycles into the current half period
	// Enable comparators: one of the two thresholds is always crossed
	assign en_rise_ok = en;
	assign en_fall_low = !en;
	// Continuous square wave while on; line rests low once removed
	always @(posedge pclk) begin
		if (!sync_on) begin
			sync <= 1'b0;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			sync <= !sync;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // bsseq_sync_src
`default_nettype wire

// ### test/tb_bsseq_top.sv
// Self-checking bench for the buck start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_bsseq_top;
	// Clock, reset and bus
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, v;
	// Flags, mode pins and outputs
	logic en = 1'b0, vin_ok = 1'b1, por_ok = 1'b1, pll = 1'b0, fb_low = 1'b1;
	logic clamp = 1'b0, comp = 1'b1, trip = 1'b0, izero = 1'b0, fsel = 1'b0;
	logic llc = 1'b1, sync_on = 1'b0, en_rise_ok, en_fall_low, sync;
	logic hs, ls, ckout, pg_out, pg_oe, pre, ssr, irq;
	int n_errors = 0, n_checks = 0, cyc = 0;
	longint t0;
	bsseq_top #(.CAL_CYC(20), .SSEND_CYC(30), .LOSS_CYC(2000),
		.RESTART_CYC(50)) bsseq_top_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .en_rise_ok,
		.en_fall_low, .drv_supply_por_ok(por_ok), .vin_ok, .vcc_ok(1'b1),
		.pll_locked(pll), .fb_below_low(fb_low), .ss_clamp_reached(clamp),
		.comp_above_offset(comp), .pwm_trip(trip), .inductor_zero(izero),
		.fault_response_select(fsel), .light_load_choice(llc),
		.freq_set_sync_input(sync), .high_side_gate(hs), .low_side_gate(ls),
		.switching_clock_output(ckout), .power_good_out(pg_out),
		.power_good_oe(pg_oe), .softstart_preload(pre),
		.softstart_run(ssr), .irq);
	bsseq_sync_src bsseq_sync_src_inst (.pclk, .en, .sync_on, .en_rise_ok,
		.en_fall_low, .sync);
	// 25 MHz clock
	initial begin
		forever #20 pclk = ~pclk;
	end
	// Current-sense stand-ins end pulses early; run ceiling
	always @(posedge pclk) begin
		trip <= hs;
		izero <= ls;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Poll the phase field until it shows the wanted phase
	task automatic wait_st(input logic [2:0] s);
		do apb(1'b0, 8'h04, 32'h0); while (v[2:0] !== s);
	endtask
	function automatic logic [31:0] since(input longint t);
		return 32'(($time - t) / 40);
	endfunction
	task automatic complete_run();
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Two start-ups: zero-current mode, then forced PWM on external clock
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(v, 32'h53);
		apb(1'b0, 8'h04, 32'h0);
		chk(v, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(e), 32'h1);
		en <= 1'b1;
		wait_st(3'h3);
		chk(32'(v[8:4]), 32'h2);
		pll <= 1'b1;
		wait_st(3'h5);
		chk(32'(v[7]), 32'h1);
		@(posedge hs);
		t0 = $time;
		@(negedge hs);
		chk(since(t0), 32'h5);
		@(posedge hs);
		chk(since(t0), 32'h1f4);
		fb_low <= 1'b0;
		clamp <= 1'b1;
		wait_st(3'h6);
		chk(32'(pg_oe), 32'h0);
		apb(1'b1, 8'h0c, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		chk(v, 32'h1);
		chk(32'(irq), 32'h1);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		chk(32'(irq), 32'h0);
		repeat (1000) @(posedge pclk);
		en <= 1'b0;
		wait_st(3'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(v, 32'h4);
		llc <= 1'b0;
		fsel <= 1'b1;
		sync_on <= 1'b1;
		en <= 1'b1;
		wait_st(3'h5);
		chk(32'(v[7]), 32'h0);
		repeat (3000) @(posedge pclk);
		apb(1'b0, 8'h04, 32'h0);
		chk(32'(v[8:4]), 32'h15);
		@(posedge sync);
		t0 = $time;
		@(posedge hs);
		chk(32'(since(t0) inside {[32'h8:32'hc]}), 32'h1);
		t0 = $time;
		@(posedge ckout);
		chk(32'(since(t0) inside {[32'h31:32'h33]}), 32'h1);
		sync_on <= 1'b0;
		wait_st(3'h7);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(v[1]), 32'h1);
		wait_st(3'h4);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(v[3]), 32'h1);
		complete_run();
	end
endmodule // tb_bsseq_top
`default_nettype wire
